// ### common/m8ap_pkg.sv
// constants, enumerations and microword layout for the 8-bit arithmetic processor
package m8ap_pkg;
  localparam int STACK_DEPTH = 4;
  localparam logic [7:0] CYC_LAST = 8'hfe;
  localparam logic [7:0] CYC_END = 8'hff;
  localparam logic [3:0] CYC_FILL = 4'hf;
  localparam logic [4:0] A_IDLE = 5'h00;
  localparam logic [4:0] A_INIT = 5'h01;
  localparam logic [4:0] A_PSEL = 5'h02;
  localparam logic [4:0] A_MCALL = 5'h03;
  localparam logic [4:0] A_MEND = 5'h04;
  localparam logic [4:0] A_MSHR = 5'h07;
  localparam logic [4:0] A_ADD = 5'h0c;
  localparam logic [4:0] A_DWAIT = 5'h0f;
  localparam logic [4:0] A_DLINK = 5'h10;
  localparam logic [4:0] A_DSHL = 5'h11;
  localparam logic [4:0] A_DSTEP = 5'h12;
  localparam logic [4:0] A_DLAST = 5'h13;
  localparam logic [4:0] A_DDONE = 5'h1c;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam int CTRL_START_BIT = 0;
  localparam int ST_LINK_LSB = 8;
  localparam int ST_COUNT_LSB = 16;
  localparam int ST_WAIT_BIT = 24;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    incr_op = 3'b000,
    direct_jump_op = 3'b001,
    port_jump_op = 3'b010,
    repeat_call_op = 3'b011,
    call_subroutine_op = 3'b100,
    return_op = 3'b101,
    conditional_branch_op = 3'b110,
    start_branch_op = 3'b111
  } m8ap_seq_t;

  typedef enum logic [2:0] {
    tst_none = 3'b000, tst_zero = 3'b001, tst_lsb = 3'b010,
    tst_cout = 3'b011, tst_link = 3'b100, tst_more = 3'b101
  } m8ap_tst_t;

  typedef enum logic [1:0] {pg_keep = 2'b00, pg_taken = 2'b01, pg_clear = 2'b10} m8ap_pg_t;

  typedef enum logic [4:0] {
    u_nop = 5'b00000, u_show = 5'b00001, u_init = 5'b00010, u_ldmc = 5'b00011,
    u_add8 = 5'b00100, u_sub8 = 5'b00101, u_xor8 = 5'b00110, u_addu = 5'b00111,
    u_subu = 5'b01000, u_asr = 5'b01001, u_dload = 5'b01010, u_linkl = 5'b01011,
    u_shl = 5'b01100, u_divas = 5'b01101, u_setq = 5'b01110, u_tsub = 5'b01111,
    u_tpass = 5'b10000, u_tadd = 5'b10001, u_tsgnd = 5'b10010, u_tsgnr = 5'b10011,
    u_fixup = 5'b10100, u_fixdn = 5'b10101
  } m8ap_uop_t;

  typedef struct packed {
    m8ap_seq_t op;
    logic [3:0] nxt_addr;
    m8ap_tst_t tst;
    m8ap_pg_t pg;
    m8ap_uop_t uop;
  } m8ap_uword_t;
endpackage : m8ap_pkg

// ### rtl/m8ap_core.sv
// microcoded 8-bit arithmetic processor with sequencer, datapath and avalon slave
// Operation
// RL1: idle loop shows result until start
// RL2: start clears upper, link; loads count, lower
// RL3: select inputs pick one of five programs
// RL4: add, subtract, xor: one step into lower
// RL5: booth: subtract, add or shift only
// RL6: test link, then lsb, in turn
// RL7: arithmetic right shift, then count and test
// RL8: eight cycles give 16-bit signed product
// RL9: divide waits for second start with divisor
// RL10: second start loads dividend high, divisor
// RL11: link gets xnor of the two signs
// RL12: shift upper and lower left, link in
// RL13: add or subtract divisor by lsb, count
// RL14: last shift forces one into lower lsb
// RL15: check remainder format and correct it
// RL16: status link: page, right link, left link
// RL17: branch test from zero, lsb or carry
// RL18: call pushes address or address plus one
// RL19: return pops stack into microaddress
// RL20: port jump takes select code as address
// RL21: repeat call loads count, then increments
// RL22: start debounced to pulse by two flops
// RL23: branch jumps on true, increments on false
// RL24: four-bit next address within page
// RL25: return in repeat mode bumps counter
// RL26: one microinstruction per clock edge
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module m8ap_core
  import m8ap_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start_in,
  input wire logic [3:0] prog_sel,
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_b,
  output logic [15:0] result_out,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  logic [3:0] microaddress_register;
  logic [3:0] next_lo;
  logic page_bit, link_right, link_left, next_page;
  logic [2:0] status_link_register;
  logic [7:0] repeat_counter;
  logic [4:0] return_stack [STACK_DEPTH];
  logic [1:0] stack_ptr;
  logic [4:0] stack_top, push_val, addr;
  logic [7:0] upper_work_register, lower_work_register, operand_accumulator;
  logic start_seen, start_held, start_pulse, soft_start, bus_ack, bus_req;
  logic branch_test_input, zero_detect, carry_out, taken, push_en, pop_en, rpt_more;
  logic [3:0] next_address_field;
  logic [7:0] alu_out;
  m8ap_uword_t uw;

  function automatic logic [8:0] add_sub(input logic [7:0] x, input logic [7:0] y,
                                         input logic sub);
    add_sub = {1'b0, x} + {1'b0, sub ? ~y : y} + {8'h00, sub};
  endfunction : add_sub

  // control store; the whole program fits two 16-word pages
  function automatic m8ap_uword_t microword(input logic [4:0] a);
    case (a)
      5'h00: microword = '{start_branch_op, 4'h0, tst_none, pg_keep, u_show};
      5'h01: microword = '{repeat_call_op, 4'h8, tst_none, pg_keep, u_init};
      5'h02: microword = '{port_jump_op, 4'h0, tst_none, pg_keep, u_nop};
      5'h03: microword = '{call_subroutine_op, 4'h5, tst_none, pg_keep, u_ldmc};
      5'h05: microword = '{conditional_branch_op, 4'h9, tst_link, pg_keep, u_nop};
      5'h06: microword = '{conditional_branch_op, 4'h8, tst_lsb, pg_keep, u_nop};
      5'h07: microword = '{return_op, 4'h0, tst_none, pg_keep, u_asr};
      5'h08: microword = '{direct_jump_op, 4'h7, tst_none, pg_keep, u_subu};
      5'h09: microword = '{conditional_branch_op, 4'h7, tst_lsb, pg_keep, u_nop};
      5'h0a: microword = '{direct_jump_op, 4'h7, tst_none, pg_keep, u_addu};
      5'h0c: microword = '{direct_jump_op, 4'h0, tst_none, pg_keep, u_add8};
      5'h0d: microword = '{direct_jump_op, 4'h0, tst_none, pg_keep, u_sub8};
      5'h0e: microword = '{direct_jump_op, 4'h0, tst_none, pg_keep, u_xor8};
      5'h0f: microword = '{start_branch_op, 4'hf, tst_none, pg_taken, u_dload};
      5'h10: microword = '{incr_op, 4'h0, tst_none, pg_keep, u_linkl};
      5'h11: microword = '{incr_op, 4'h0, tst_none, pg_keep, u_shl};
      5'h12: microword = '{conditional_branch_op, 4'h0, tst_more, pg_keep, u_divas};
      5'h13: microword = '{incr_op, 4'h0, tst_none, pg_keep, u_setq};
      5'h14: microword = '{conditional_branch_op, 4'ha, tst_zero, pg_keep, u_tsub};
      5'h15: microword = '{conditional_branch_op, 4'hc, tst_zero, pg_keep, u_tpass};
      5'h16: microword = '{conditional_branch_op, 4'h9, tst_zero, pg_keep, u_tadd};
      5'h17: microword = '{conditional_branch_op, 4'hc, tst_cout, pg_keep, u_tsgnd};
      5'h18: microword = '{conditional_branch_op, 4'ha, tst_cout, pg_keep, u_tsgnr};
      5'h19: microword = '{direct_jump_op, 4'h0, tst_none, pg_clear, u_fixdn};
      5'h1a: microword = '{direct_jump_op, 4'h0, tst_none, pg_clear, u_fixup};
      default: microword = '{direct_jump_op, 4'h0, tst_none, pg_clear, u_nop};
    endcase
  endfunction : microword

  assign status_link_register = {link_left, link_right, page_bit}; // RL16
  assign addr = {page_bit, microaddress_register}; // RL24
  assign uw = microword(addr);
  assign next_address_field = uw.nxt_addr;
  assign stack_top = return_stack[stack_ptr - 2'h1];
  assign rpt_more = repeat_counter < CYC_LAST;

  // start shaping: a held button gives one pulse only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      start_seen <= 1'b0;
      start_held <= 1'b0;
    end else begin
      start_seen <= start_in; // RL22
      start_held <= start_seen; // RL22
    end
  end
  assign start_pulse = (start_seen & ~start_held) | soft_start; // RL22

  // alu and the flags it feeds to the branch test
  always_comb begin
    logic [8:0] r;
    r = add_sub(upper_work_register, operand_accumulator, 1'b0);
    alu_out = upper_work_register;
    carry_out = 1'b0;
    case (uw.uop)
      u_add8: r = add_sub(port_a, port_b, 1'b0); // RL4
      u_sub8: r = add_sub(port_a, port_b, 1'b1); // RL4
      u_subu, u_tsub, u_fixup: r = add_sub(upper_work_register, operand_accumulator, 1'b1);
      u_divas: r = add_sub(upper_work_register, operand_accumulator,
                           lower_work_register[0]); // RL13
      default: r = add_sub(upper_work_register, operand_accumulator, 1'b0);
    endcase
    case (uw.uop)
      u_add8, u_sub8, u_addu, u_subu, u_divas, u_tsub, u_tadd, u_fixup, u_fixdn: begin
        alu_out = r[7:0];
        carry_out = r[8];
      end
      u_xor8: alu_out = port_a ^ port_b; // RL4
      u_tsgnd: carry_out = ~(upper_work_register[7] ^ port_a[7]); // RL15
      u_tsgnr, u_linkl: carry_out = ~(upper_work_register[7] ^ operand_accumulator[7]);
      default: alu_out = upper_work_register;
    endcase
  end
  assign zero_detect = alu_out == 8'h00;

  always_comb begin
    case (uw.tst)
      tst_zero: branch_test_input = zero_detect; // RL17
      tst_lsb: branch_test_input = lower_work_register[0]; // RL17
      tst_cout: branch_test_input = carry_out; // RL17
      tst_link: branch_test_input = link_right; // RL6
      tst_more: branch_test_input = rpt_more; // RL13
      default: branch_test_input = 1'b0;
    endcase
  end

  // next address logic
  always_comb begin
    next_lo = microaddress_register + 4'h1;
    push_en = 1'b0;
    pop_en = 1'b0;
    push_val = addr + 5'h01;
    taken = 1'b0;
    case (uw.op)
      direct_jump_op: next_lo = next_address_field;
      port_jump_op: next_lo = prog_sel; // RL3 RL20
      call_subroutine_op: begin
        next_lo = next_address_field; // RL18
        push_en = 1'b1;
        if (rpt_more) push_val = addr; // RL8 RL18
      end
      return_op: begin
        next_lo = stack_top[3:0]; // RL19
        pop_en = 1'b1;
      end
      conditional_branch_op: begin
        taken = branch_test_input;
        if (taken) next_lo = next_address_field; // RL23
      end
      start_branch_op: begin
        taken = start_pulse;
        if (!taken) next_lo = next_address_field; // RL1 RL9
      end
      default: next_lo = microaddress_register + 4'h1;
    endcase
    case (uw.pg)
      pg_taken: next_page = taken;
      pg_clear: next_page = 1'b0;
      default: next_page = pop_en ? stack_top[4] : page_bit;
    endcase
  end

  // one microword per edge; sequencer and datapath move together
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      microaddress_register <= 4'h0;
      page_bit <= 1'b0;
    end else begin
      microaddress_register <= next_lo; // RL26
      page_bit <= next_page; // RL16
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stack_ptr <= 2'h0;
    end else if (push_en) begin
      return_stack[stack_ptr] <= push_val; // RL18
      stack_ptr <= stack_ptr + 2'h1;
    end else if (pop_en) begin
      stack_ptr <= stack_ptr - 2'h1; // RL19
    end
  end

  // count runs up from the complement of eight to the end value
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      repeat_counter <= CYC_END;
    end else if (uw.op == repeat_call_op) begin
      repeat_counter <= {CYC_FILL, ~next_address_field}; // RL2 RL21
    end else if ((pop_en || uw.uop == u_divas) && repeat_counter != CYC_END) begin
      repeat_counter <= repeat_counter + 8'h01; // RL7 RL13 RL25
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      upper_work_register <= 8'h00;
      lower_work_register <= 8'h00;
      operand_accumulator <= 8'h00;
      link_right <= 1'b0;
      link_left <= 1'b0;
    end else begin
      case (uw.uop)
        u_init: begin
          upper_work_register <= 8'h00; // RL2
          lower_work_register <= port_b; // RL2 RL9
          link_right <= 1'b0;
          link_left <= 1'b0;
        end
        u_ldmc: operand_accumulator <= port_a;
        u_add8, u_sub8, u_xor8: lower_work_register <= alu_out; // RL4
        u_addu, u_subu, u_divas: upper_work_register <= alu_out; // RL5 RL13
        u_asr: begin
          {upper_work_register, lower_work_register} <=
            {upper_work_register[7], upper_work_register, lower_work_register[7:1]}; // RL7
          link_right <= lower_work_register[0]; // RL7
        end
        u_dload: if (start_pulse) begin
          upper_work_register <= port_a; // RL10
          operand_accumulator <= port_b; // RL10
        end
        u_linkl: link_left <= carry_out; // RL11
        u_shl: {upper_work_register, lower_work_register} <=
          {upper_work_register[6:0], lower_work_register, link_left}; // RL12
        u_setq: begin
          link_left <= 1'b1; // RL14
          lower_work_register <= {lower_work_register[6:0], 1'b1}; // RL14
        end
        u_fixup: begin
          upper_work_register <= alu_out; // RL15
          lower_work_register <= lower_work_register + 8'h01;
        end
        u_fixdn: begin
          upper_work_register <= alu_out; // RL15
          lower_work_register <= lower_work_register - 8'h01;
        end
        default: operand_accumulator <= operand_accumulator;
      endcase
    end
  end

  // display follows the working registers only while idling
  always_ff @(posedge clk_sys) begin
    if (!rst_n) result_out <= RESULT_RESET;
    else if (uw.uop == u_show) result_out <= {upper_work_register, lower_work_register}; // RL1
  end

  // avalon slave: every access takes exactly one wait cycle
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) bus_ack <= 1'b0;
    else bus_ack <= bus_req & ~bus_ack;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_readdata <= UNMAPPED_DATA;
    end else if (avs_read && !bus_ack) begin
      case (avs_address)
        REG_STATUS: begin
          avs_readdata <= UNMAPPED_DATA;
          avs_readdata[4:0] <= addr;
          avs_readdata[ST_LINK_LSB +: 3] <= status_link_register;
          avs_readdata[ST_COUNT_LSB +: 8] <= repeat_counter;
          avs_readdata[ST_WAIT_BIT] <= uw.op == start_branch_op;
        end
        REG_RESULT: avs_readdata <= {16'h0000, upper_work_register, lower_work_register};
        default: avs_readdata <= UNMAPPED_DATA;
      endcase
    end
  end

  // soft start joins the shaped pulse; it is lost unless a start loop waits
  always_ff @(posedge clk_sys) begin
    if (!rst_n) soft_start <= 1'b0;
    else soft_start <= avs_write && bus_ack && avs_byteenable[0] &&
                       avs_address == REG_CTRL && avs_writedata[CTRL_START_BIT];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic [7:0] chk_sum;
  assign chk_sum = port_a + port_b;

  idle_loop_a: assert property ( // RL1
    addr == A_IDLE && !start_pulse |=> addr == A_IDLE &&
      result_out == {$past(upper_work_register), $past(lower_work_register)})
    else $error("idle loop left without start");
  init_load_a: assert property ( // RL2
    addr == A_INIT |=> upper_work_register == 8'h00 && !link_right &&
      repeat_counter == 8'hf7 && lower_work_register == $past(port_b))
    else $error("start initialisation wrong");
  prog_jump_a: assert property ( // RL20
    addr == A_PSEL |=> addr == {1'b0, $past(prog_sel)})
    else $error("program select jump wrong");
  single_step_a: assert property ( // RL4
    addr == A_ADD |=> lower_work_register == $past(chk_sum) && addr == A_IDLE &&
      upper_work_register == 8'h00)
    else $error("add step wrong");
  booth_shift_a: assert property ( // RL7
    addr == A_MSHR |=> link_right == $past(lower_work_register[0]) &&
      upper_work_register[7] == $past(upper_work_register[7]) &&
      lower_work_register[7] == $past(upper_work_register[0]))
    else $error("multiply shift wrong");
  mul_done_a: assert property ( // RL8
    addr == A_MCALL && repeat_counter == CYC_LAST |-> ##[4:5] addr == A_MEND)
    else $error("multiply did not end after last cycle");
  divide_link_a: assert property ( // RL11
    addr == A_DLINK |=> link_left ==
      ~($past(upper_work_register[7]) ^ $past(operand_accumulator[7])))
    else $error("divide link wrong");
  divide_shift_a: assert property ( // RL12
    addr == A_DSHL |=> lower_work_register[0] == $past(link_left) &&
      upper_work_register[0] == $past(lower_work_register[7]))
    else $error("divide shift wrong");
  divide_loop_a: assert property ( // RL13
    addr == A_DSTEP |=> addr == ($past(rpt_more) ? A_DLINK : A_DLAST))
    else $error("divide loop count wrong");
  divide_last_a: assert property ( // RL14
    addr == A_DLAST |=> lower_work_register[0] && link_left)
    else $error("final quotient bit not forced");
  call_return_a: assert property ( // RL19
    uw.op == return_op |=> addr == $past(stack_top))
    else $error("return address wrong");
  start_shape_a: assert property ( // RL22
    start_seen && !start_held |-> start_pulse ##1 (start_held && start_pulse == soft_start))
    else $error("start pulse not single");
  result_hold_a: assert property ( // RL1
    addr != A_IDLE |=> $stable(result_out))
    else $error("display changed outside the idle loop");
  divide_load_a: assert property ( // RL10
    addr == A_DWAIT && start_pulse |=> addr == A_DLINK &&
      upper_work_register == $past(port_a) && operand_accumulator == $past(port_b))
    else $error("second divide start load wrong");
  branch_step_a: assert property ( // RL23
    uw.op == conditional_branch_op |=> microaddress_register ==
      ($past(branch_test_input) ? $past(next_address_field) :
       $past(microaddress_register) + 4'h1))
    else $error("conditional branch target wrong");
  stack_push_a: assert property ( // RL18
    uw.op == call_subroutine_op |=>
      stack_top == ($past(rpt_more) ? $past(addr) : $past(addr) + 5'h01))
    else $error("call pushed wrong return address");

  mul_seen_c: cover property (addr == A_MEND);
  div_seen_c: cover property (addr == A_DDONE);
  div_fix_c: cover property (uw.uop == u_fixup || uw.uop == u_fixdn);
  bus_write_c: cover property (soft_start);
  mul_last_c: cover property (uw.op == call_subroutine_op && !rpt_more);
endmodule : m8ap_core
`default_nettype wire

// ### sim/m8ap_operator.sv
// operator model: select switches, operand switches and start pushbutton
`timescale 1ns/1ns
`default_nettype none
module m8ap_operator (
  input wire logic clk_sys,
  output logic start_in,
  output logic [3:0] prog_sel,
  output logic [7:0] port_a,
  output logic [7:0] port_b
);
  initial begin
    start_in = 1'b0;
    prog_sel = 4'h0;
    port_a = 8'h00;
    port_b = 8'h00;
  end
  // switches stay put until the next setting, as a real panel does
  task automatic set_sw(input logic [3:0] sel, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_sys);
    prog_sel <= sel;
    port_a <= a;
    port_b <= b;
  endtask : set_sw
  // divide takes two presses: dividend low first, then dividend high and divisor
  task automatic press(input logic [3:0] sel, input logic [7:0] a, input logic [7:0] b,
                       input int hold, input logic let_go);
    set_sw(sel, a, b);
    start_in <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    if (let_go) begin
      start_in <= 1'b0;
    end
  endtask : press
  task automatic release_btn();
    @(posedge clk_sys);
    start_in <= 1'b0;
  endtask : release_btn
endmodule : m8ap_operator
`default_nettype wire

// ### sim/m8ap_core_tb_top.sv
// self-checking bench for the 8-bit arithmetic processor
`timescale 1ns/1ns
`default_nettype none
module m8ap_core_tb_top
  import m8ap_pkg::*;
;
  localparam int TIMEOUT_CYC = 20000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  wire logic start_in;
  wire logic [3:0] prog_sel;
  wire logic [7:0] port_a;
  wire logic [7:0] port_b;
  logic [15:0] result_out;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  always #50 clk_sys = ~clk_sys;

  m8ap_core i_m8ap_core (.clk_sys(clk_sys), .rst_n(rst_n), .start_in(start_in),
    .prog_sel(prog_sel), .port_a(port_a), .port_b(port_b), .result_out(result_out),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  m8ap_operator i_m8ap_operator (.clk_sys(clk_sys), .start_in(start_in),
    .prog_sel(prog_sel), .port_a(port_a), .port_b(port_b));

  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is seen low; only the bench timeout ends a stuck wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= 4'hf;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // readdata is registered, so let the machine move before trusting the address
  task automatic wait_addr(input logic [4:0] a);
    logic [31:0] s;
    s = 32'hffff_ffff;
    repeat (2) @(posedge clk_sys);
    while (s[4:0] !== a) begin
      bus(1'b0, REG_STATUS, 32'h0, s);
    end
  endtask : wait_addr

  task automatic settle_chk(input logic [15:0] exp);
    logic [31:0] rd;
    repeat (3) @(posedge clk_sys);
    chk({16'h0, result_out}, {16'h0, exp});
    bus(1'b0, REG_RESULT, 32'h0, rd);
    chk(rd, {16'h0, exp});
  endtask : settle_chk

  task automatic run_chk(input logic [3:0] sel, input logic [7:0] a, input logic [7:0] b,
                         input int hold, input logic [15:0] exp);
    i_m8ap_operator.press(sel, a, b, hold, 1'b1);
    wait_addr(A_IDLE);
    settle_chk(exp);
  endtask : run_chk

  task automatic t_reset();
    logic [31:0] rd;
    chk({16'h0, result_out}, {16'h0, RESULT_RESET});
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, 32'h01ff_0000);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk(rd, UNMAPPED_DATA);
  endtask : t_reset

  task automatic t_alu();
    logic [7:0] a[2] = '{8'hff, 8'h80};
    logic [7:0] b[2] = '{8'h01, 8'h7f};
    logic [7:0] r;
    logic [31:0] rd;
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 3; k++) begin
        r = (k == 0) ? a[i] + b[i] : (k == 1) ? a[i] - b[i] : a[i] ^ b[i];
        run_chk(4'hc + 4'(k), a[i], b[i], 3, {8'h00, r});
      end
    end
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, 32'h01f7_0000);
    run_chk(4'h0, 8'h5a, 8'h3c, 3, 16'h003c);
  endtask : t_alu

  task automatic t_mul();
    // a multiplicand of -128 overflows the 8-bit upper register, so the panel avoids it
    logic [7:0] ma[5] = '{8'h03, 8'hff, 8'h81, 8'h7f, 8'hfd};
    logic [7:0] mb[5] = '{8'h05, 8'h01, 8'h80, 8'h81, 8'h07};
    int p;
    for (int i = 0; i < 5; i++) begin
      p = int'($signed(ma[i])) * int'($signed(mb[i]));
      run_chk(4'h3, ma[i], mb[i], 3 + 6 * (i % 2), p[15:0]);
    end
  endtask : t_mul

  task automatic t_div();
    int dd[5] = '{37, -37, 37, -36, 1000};
    int ds[5] = '{6, 6, -6, 6, 9};
    int q;
    int r;
    logic [31:0] s;
    for (int i = 0; i < 5; i++) begin
      q = dd[i] / ds[i];
      r = dd[i] % ds[i];
      i_m8ap_operator.press(4'hf, 8'h00, dd[i][7:0], 3, 1'b1);
      wait_addr(A_DWAIT);
      bus(1'b0, REG_STATUS, 32'h0, s);
      chk({31'h0, s[ST_WAIT_BIT]}, 32'h1);
      run_chk(4'hf, dd[i][15:8], ds[i][7:0], 3, {r[7:0], q[7:0]});
    end
  endtask : t_div

  // a held button must give one run only; the loop keeps showing the old answer
  task automatic t_held_soft();
    logic [31:0] rd;
    i_m8ap_operator.press(4'hc, 8'h01, 8'h02, 3, 1'b0);
    wait_addr(A_IDLE);
    settle_chk(16'h0003);
    i_m8ap_operator.set_sw(4'hc, 8'h10, 8'h20);
    repeat (30) @(posedge clk_sys);
    chk({16'h0, result_out}, 32'h0000_0003);
    i_m8ap_operator.release_btn();
    bus(1'b1, 4'hc, 32'h1, rd);
    repeat (30) @(posedge clk_sys);
    chk({16'h0, result_out}, 32'h0000_0003);
    bus(1'b1, REG_CTRL, 32'h1, rd);
    wait_addr(A_IDLE);
    settle_chk(16'h0030);
  endtask : t_held_soft

  task automatic t_midreset();
    logic [31:0] rd;
    i_m8ap_operator.press(4'h3, 8'h7f, 8'h7f, 3, 1'b1);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk({16'h0, result_out}, {16'h0, RESULT_RESET});
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, 32'h01ff_0000);
  endtask : t_midreset

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYC) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_alu();
    t_mul();
    t_div();
    t_held_soft();
    t_midreset();
    summarize();
  end
endmodule : m8ap_core_tb_top
`default_nettype wire
